// >>> src/dkm_pkg.sv
// Shared constants and types for the display knob and menu control.
// Assumes a single system clock at CLK_HZ; all times are in milliseconds.
package dkm_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned STEP_SLOW_MS = 500;
  localparam int unsigned STEP_FAST_MS = 100;
  localparam int unsigned HOLD_FAST_MS = 2000;
  localparam int unsigned LINK_WAIT_MS = 5000;
  localparam int unsigned BLINK_MS = 250;
  localparam logic [31:0] DEBOUNCE_CYC = 32'(CYC_PER_MS * DEBOUNCE_MS);
  localparam logic [31:0] STEP_SLOW_CYC = 32'(CYC_PER_MS * STEP_SLOW_MS);
  localparam logic [31:0] STEP_FAST_CYC = 32'(CYC_PER_MS * STEP_FAST_MS);
  localparam logic [31:0] HOLD_FAST_CYC = 32'(CYC_PER_MS * HOLD_FAST_MS);
  localparam logic [31:0] LINK_WAIT_CYC = 32'(CYC_PER_MS * LINK_WAIT_MS);
  localparam logic [31:0] BLINK_CYC = 32'(CYC_PER_MS * BLINK_MS);
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam int unsigned KNOB_INPUTS = 6;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_LOCAL = 2'b01,
    MODE_REMOTE = 2'b10
  } dkm_mode_type;

  typedef enum logic [1:0] {
    ROLE_LOCAL = 2'b00,
    ROLE_UNIT1 = 2'b01,
    ROLE_UNIT2 = 2'b10,
    ROLE_CONFLICT = 2'b11
  } dkm_role_type;
endpackage

// >>> src/dkm_debounce.sv
// Two-flop synchroniser followed by a stability debouncer for one pin.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module dkm_debounce
  import dkm_pkg::*;
#(
  parameter logic [31:0] STABLE_CYC = DEBOUNCE_CYC
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_raw,
  output logic level
);
  logic sync1_reg;
  logic sync2_reg;
  logic [31:0] cnt_reg;

  always_ff @(posedge clk_sys)
  begin
    sync1_reg <= reset ? 1'b0 : pin_raw;
    sync2_reg <= reset ? 1'b0 : sync1_reg;
  end

  // Level changes only after the synced pin has held for STABLE_CYC
  always_ff @(posedge clk_sys)
  begin
    if (reset || sync2_reg == level)
      cnt_reg <= CNT_ZERO;
    else
      cnt_reg <= cnt_reg + CNT_ONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      level <= 1'b0;
    else if (sync2_reg != level && cnt_reg + CNT_ONE >= STABLE_CYC)
      level <= sync2_reg;
  end
endmodule

// >>> src/dkm_hold_timer.sv
// Auto-repeat timer for a held knob position.
// Assumes held is already debounced and on clk_sys.
`timescale 1ns/1ps
module dkm_hold_timer
  import dkm_pkg::*;
#(
  parameter logic [31:0] SLOW_CYC = STEP_SLOW_CYC,
  parameter logic [31:0] FAST_CYC = STEP_FAST_CYC,
  parameter logic [31:0] FAST_AFTER_CYC = HOLD_FAST_CYC
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic held,
  output logic step,
  output logic repeating
);
  logic [31:0] hold_cnt_reg;
  logic [31:0] per_cnt_reg;
  logic fast;
  logic hit;

  assign fast = hold_cnt_reg >= FAST_AFTER_CYC;
  assign hit = held && (per_cnt_reg + CNT_ONE >= (fast ? FAST_CYC : SLOW_CYC));

  always_ff @(posedge clk_sys)
  begin
    if (reset || !held)
      hold_cnt_reg <= CNT_ZERO;
    else if (!fast)
      hold_cnt_reg <= hold_cnt_reg + CNT_ONE;
  end

  // Slow period first, fast period once the hold passes the threshold
  always_ff @(posedge clk_sys)
  begin
    if (reset || !held || hit) // [RL6]
      per_cnt_reg <= CNT_ZERO;
    else
      per_cnt_reg <= per_cnt_reg + CNT_ONE;
  end

  always_ff @(posedge clk_sys)
  begin
    step <= reset ? 1'b0 : hit;
  end

  // Repeating stays set until release so release adds no extra step
  always_ff @(posedge clk_sys)
  begin
    if (reset || !held)
      repeating <= 1'b0;
    else if (hit)
      repeating <= 1'b1;
  end

  a_slow_period: assert property (@(posedge clk_sys) disable iff (reset)
    hit && !fast |-> per_cnt_reg == SLOW_CYC - CNT_ONE) // [RL6]
    else $error("slow step period wrong");
  a_fast_period: assert property (@(posedge clk_sys) disable iff (reset)
    hit && fast |-> per_cnt_reg == FAST_CYC - CNT_ONE) // [RL6]
    else $error("fast step period wrong");
endmodule

// >>> src/dkm_knob_menu.sv
// Display unit knob decoding, setup menu navigation, mode arbitration,
// indicators and link watchdog. Assumes setup_mode, remote unit inputs
// and valve status come from logic on clk_sys; knobs and DIP pins do not.
//
// Behaviour
// RL1: Enabled remote unit absent forces stop mode and blocks operation.
// RL2: Message area blank with no alarm, no motion, no limit reached.
// RL3: Control knob gives Open/Stop/Close locally, YES/NO in setup.
// RL4: NO during value entry only increments the value.
// RL5: Incrementing past the maximum wraps to the minimum.
// RL6: Held NO steps every 0.5 s, every 0.1 s after 2 s.
// RL7: Selector gives Local/Stop/Remote normally, NEXT/BACK in setup.
// RL8: NEXT and BACK only move among displays, never change values.
// RL9: Clockwise control in setup is YES: accept and advance display.
// RL10: Counterclockwise control in setup is NO: next value or display.
// RL11: Return to centre completes YES/NO, except after held repeats.
// RL12: Selector return to STOP completes pending NEXT or BACK.
// RL13: Selector clockwise in setup is NEXT: following display.
// RL14: Selector counterclockwise in setup is BACK: previous display.
// RL15: Selector held at NEXT or BACK keeps scrolling.
// RL16: Red, green, yellow indicators; option swaps red and green.
// RL17: Two DIP switches select local unit, remote unit one or two.
// RL18: Mode is stop if any STOP, else local if any LOCAL, else remote.
// RL19: Remote unit without messages for 5 s flags link failure, blinks.
// RL20: Knob inputs synchronised and debounced before use.
`timescale 1ns/1ps
module dkm_knob_menu
  import dkm_pkg::*;
#(
  parameter int VAL_W = 8,
  parameter int DISP_W = 5,
  parameter int DISP_N = 20,
  parameter logic [31:0] DEB_CYC = DEBOUNCE_CYC,
  parameter logic [31:0] SLOW_CYC = STEP_SLOW_CYC,
  parameter logic [31:0] FAST_CYC = STEP_FAST_CYC,
  parameter logic [31:0] FAST_AFTER_CYC = HOLD_FAST_CYC,
  parameter logic [31:0] LINK_CYC = LINK_WAIT_CYC,
  parameter logic [31:0] BLINK_HALF_CYC = BLINK_CYC
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ctl_cw_raw,
  input wire logic ctl_ccw_raw,
  input wire logic sel_cw_raw,
  input wire logic sel_ccw_raw,
  input wire logic role_select_switch_a,
  input wire logic role_select_switch_b,
  input wire logic setup_mode,
  input wire logic value_entry,
  input wire logic value_load,
  input wire logic [VAL_W-1:0] value_in,
  input wire logic [VAL_W-1:0] value_min,
  input wire logic [VAL_W-1:0] value_max,
  input wire logic rdu1_enable,
  input wire logic rdu1_present,
  input wire dkm_mode_type rdu1_select,
  input wire logic rdu2_enable,
  input wire logic rdu2_present,
  input wire dkm_mode_type rdu2_select,
  input wire logic msg_rx,
  input wire logic alarm_active,
  input wire logic valve_opening,
  input wire logic valve_closing,
  input wire logic at_open_limit,
  input wire logic at_close_limit,
  input wire logic led_swap,
  output logic cmd_open,
  output logic cmd_stop,
  output logic cmd_close,
  output dkm_mode_type op_mode,
  output logic op_blocked,
  output logic yes_pulse,
  output logic no_pulse,
  output logic next_pulse,
  output logic back_pulse,
  output logic [VAL_W-1:0] value_reg,
  output logic [DISP_W-1:0] disp_reg,
  output dkm_role_type role,
  output logic link_fail,
  output logic msg_blank,
  output logic led_red,
  output logic led_green,
  output logic led_yellow
);
  localparam logic [DISP_W-1:0] DISP_LAST = DISP_W'(DISP_N - 1);
  localparam logic [DISP_W-1:0] DISP_ONE = DISP_W'(1);
  localparam logic [DISP_W-1:0] DISP_ZERO = DISP_W'(0);
  localparam logic [VAL_W-1:0] VAL_ONE = VAL_W'(1);

  logic [KNOB_INPUTS-1:0] raw_vec;
  logic [KNOB_INPUTS-1:0] db;
  logic yes_held;
  logic no_held;
  logic next_held;
  logic back_held;
  logic nav_held;
  logic yes_prev_reg;
  logic no_prev_reg;
  logic next_prev_reg;
  logic back_prev_reg;
  logic no_step;
  logic no_rep;
  logic nav_step;
  logic nav_rep;
  logic unit1_missing;
  logic unit2_missing;
  logic any_stop;
  logic any_local;
  dkm_mode_type local_sel;
  dkm_mode_type mode_next;
  logic [31:0] link_cnt_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic red_base;
  logic green_base;
  logic stopped;

  assign raw_vec = {role_select_switch_b, role_select_switch_a,
                    sel_ccw_raw, sel_cw_raw, ctl_ccw_raw, ctl_cw_raw};

  // Every pin gets its own synchroniser and debouncer
  genvar gi;
  generate
    for (gi = 0; gi < KNOB_INPUTS; gi++)
    begin : g_deb
      dkm_debounce #(
        .STABLE_CYC(DEB_CYC)
      ) u_deb (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_raw(raw_vec[gi]),
        .level(db[gi]) // [RL20]
      );
    end
  endgenerate

  // Clockwise wins if both contacts read closed at once
  assign yes_held = setup_mode && db[0]; // [RL9]
  assign no_held = setup_mode && db[1] && !db[0]; // [RL10]
  assign next_held = setup_mode && db[2]; // [RL13]
  assign back_held = setup_mode && db[3] && !db[2]; // [RL14]
  assign nav_held = next_held || back_held;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      yes_prev_reg <= 1'b0;
      no_prev_reg <= 1'b0;
      next_prev_reg <= 1'b0;
      back_prev_reg <= 1'b0;
    end
    else
    begin
      yes_prev_reg <= yes_held;
      no_prev_reg <= no_held;
      next_prev_reg <= next_held;
      back_prev_reg <= back_held;
    end
  end

  dkm_hold_timer #(
    .SLOW_CYC(SLOW_CYC),
    .FAST_CYC(FAST_CYC),
    .FAST_AFTER_CYC(FAST_AFTER_CYC)
  ) u_no_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .held(no_held),
    .step(no_step),
    .repeating(no_rep)
  );

  // Scrolling reuses the same repeat timing as the NO key
  dkm_hold_timer #(
    .SLOW_CYC(SLOW_CYC),
    .FAST_CYC(FAST_CYC),
    .FAST_AFTER_CYC(FAST_AFTER_CYC)
  ) u_nav_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .held(nav_held),
    .step(nav_step),
    .repeating(nav_rep)
  );

  // Entry cycles complete on return to neutral
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      yes_pulse <= 1'b0;
      no_pulse <= 1'b0;
    end
    else
    begin
      yes_pulse <= yes_prev_reg && !yes_held; // [RL11]
      no_pulse <= no_step || (no_prev_reg && !no_held && !no_rep); // [RL11]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      next_pulse <= 1'b0;
      back_pulse <= 1'b0;
    end
    else
    begin
      next_pulse <= (next_held && nav_step) || // [RL15]
                    (next_prev_reg && !next_held && !nav_rep); // [RL12]
      back_pulse <= (back_held && nav_step) || // [RL15]
                    (back_prev_reg && !back_held && !nav_rep); // [RL12]
    end
  end

  // Value only counts up; lower values are reached by wrapping
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      value_reg <= '0;
    else if (value_load)
      value_reg <= value_in;
    else if (no_pulse && value_entry)
    begin
      if (value_reg >= value_max) // [RL5]
        value_reg <= value_min;
      else
        value_reg <= value_reg + VAL_ONE; // [RL4]
    end
  end

  // Display index; NEXT/BACK touch only this, never the value
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      disp_reg <= DISP_ZERO;
    else if (back_pulse) // [RL8]
      disp_reg <= (disp_reg == DISP_ZERO) ? DISP_LAST : disp_reg - DISP_ONE;
    else if (next_pulse || yes_pulse || (no_pulse && !value_entry)) // [RL9]
      disp_reg <= (disp_reg >= DISP_LAST) ? DISP_ZERO : disp_reg + DISP_ONE;
  end

  // Local selector position; setup mode holds the local unit at stop
  always_comb
  begin
    local_sel = MODE_STOP;
    if (!setup_mode && db[2]) // [RL7]
      local_sel = MODE_REMOTE;
    else if (!setup_mode && db[3])
      local_sel = MODE_LOCAL;
  end

  assign unit1_missing = rdu1_enable && !rdu1_present;
  assign unit2_missing = rdu2_enable && !rdu2_present;
  assign any_stop = local_sel == MODE_STOP ||
    (rdu1_enable && rdu1_present && rdu1_select == MODE_STOP) ||
    (rdu2_enable && rdu2_present && rdu2_select == MODE_STOP);
  assign any_local = local_sel == MODE_LOCAL ||
    (rdu1_enable && rdu1_present && rdu1_select == MODE_LOCAL) ||
    (rdu2_enable && rdu2_present && rdu2_select == MODE_LOCAL);

  always_comb
  begin
    case ({unit1_missing || unit2_missing, any_stop, any_local})
      3'b000: mode_next = MODE_REMOTE;
      3'b001: mode_next = MODE_LOCAL; // [RL18]
      default: mode_next = MODE_STOP; // [RL1]
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      op_mode <= MODE_STOP;
      op_blocked <= 1'b1;
    end
    else
    begin
      op_mode <= mode_next;
      op_blocked <= unit1_missing || unit2_missing; // [RL1]
    end
  end

  // Local run commands only from the local unit outside setup
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cmd_open <= 1'b0;
      cmd_close <= 1'b0;
      cmd_stop <= 1'b1;
    end
    else
    begin
      cmd_close <= mode_next == MODE_LOCAL && !setup_mode && db[0]; // [RL3]
      cmd_open <= mode_next == MODE_LOCAL && !setup_mode &&
                  db[1] && !db[0]; // [RL3]
      cmd_stop <= !(mode_next == MODE_LOCAL && !setup_mode &&
                    (db[0] || db[1]));
    end
  end

  // Role taken from debounced DIP switches, so a strap read stays clean
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      role <= ROLE_LOCAL;
    else
      role <= dkm_role_type'({db[5], db[4]}); // [RL17]
  end

  // Watchdog restarts on every message; only remote roles report it
  always_ff @(posedge clk_sys)
  begin
    if (reset || msg_rx)
      link_cnt_reg <= CNT_ZERO;
    else if (link_cnt_reg < LINK_CYC)
      link_cnt_reg <= link_cnt_reg + CNT_ONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      link_fail <= 1'b0;
    else
      link_fail <= (role == ROLE_UNIT1 || role == ROLE_UNIT2) &&
                   !msg_rx && link_cnt_reg >= LINK_CYC; // [RL19]
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || blink_cnt_reg + CNT_ONE >= BLINK_HALF_CYC)
      blink_cnt_reg <= CNT_ZERO;
    else
      blink_cnt_reg <= blink_cnt_reg + CNT_ONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      blink_reg <= 1'b0;
    else if (blink_cnt_reg + CNT_ONE >= BLINK_HALF_CYC)
      blink_reg <= !blink_reg;
  end

  assign stopped = !valve_opening && !valve_closing &&
                   !at_open_limit && !at_close_limit;
  assign red_base = at_open_limit || (valve_opening && blink_reg);
  assign green_base = at_close_limit || (valve_closing && blink_reg);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      msg_blank <= 1'b1;
    else
      msg_blank <= !alarm_active && stopped; // [RL2]
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      led_red <= 1'b0;
      led_green <= 1'b0;
      led_yellow <= 1'b0;
    end
    else if (link_fail)
    begin
      led_red <= blink_reg; // [RL19]
      led_green <= blink_reg;
      led_yellow <= blink_reg;
    end
    else
    begin
      led_red <= led_swap ? green_base : red_base; // [RL16]
      led_green <= led_swap ? red_base : green_base; // [RL16]
      led_yellow <= alarm_active ? blink_reg : stopped;
    end
  end

  sequence s_no_tap;
    no_prev_reg && !no_held && !no_rep;
  endsequence

  sequence s_sel_return;
    next_prev_reg && !next_held && !nav_rep;
  endsequence

  a_missing_stop: assert property (@(posedge clk_sys) disable iff (reset)
    unit1_missing || unit2_missing |=> op_mode == MODE_STOP && op_blocked) // [RL1]
    else $error("absent unit did not force stop");
  a_blank_msg: assert property (@(posedge clk_sys) disable iff (reset)
    alarm_active || !stopped |=> !msg_blank) // [RL2]
    else $error("message area blank while active");
  a_setup_nocmd: assert property (@(posedge clk_sys) disable iff (reset)
    setup_mode |=> !cmd_open && !cmd_close && cmd_stop) // [RL3]
    else $error("run command issued in setup");
  a_value_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    no_pulse && value_entry && !value_load && value_reg >= value_max
    |=> value_reg == $past(value_min)) // [RL5]
    else $error("value did not wrap to minimum");
  a_value_up: assert property (@(posedge clk_sys) disable iff (reset)
    no_pulse && value_entry && !value_load && value_reg < value_max
    |=> value_reg == $past(value_reg) + VAL_ONE) // [RL4]
    else $error("value did not step up by one");
  a_nav_value: assert property (@(posedge clk_sys) disable iff (reset)
    (next_pulse || back_pulse) && !no_pulse && !value_load
    |=> $stable(value_reg)) // [RL8]
    else $error("navigation changed the value");
  a_no_complete: assert property (@(posedge clk_sys) disable iff (reset)
    s_no_tap |=> no_pulse ##1 !no_pulse) // [RL11]
    else $error("NO entry not completed on release");
  a_next_complete: assert property (@(posedge clk_sys) disable iff (reset)
    s_sel_return |=> next_pulse && !back_pulse) // [RL12]
    else $error("NEXT entry not completed at STOP");
  a_back_move: assert property (@(posedge clk_sys) disable iff (reset)
    back_pulse && disp_reg != DISP_ZERO
    |=> disp_reg == $past(disp_reg) - DISP_ONE) // [RL14]
    else $error("BACK did not go to previous display");
  a_any_stop: assert property (@(posedge clk_sys) disable iff (reset)
    any_stop |=> op_mode == MODE_STOP) // [RL18]
    else $error("stop selection not obeyed");
  a_link_blink: assert property (@(posedge clk_sys) disable iff (reset)
    link_fail |=> led_red == led_green && led_green == led_yellow) // [RL19]
    else $error("indicators not blinking together");
endmodule

// >>> verification/dkm_knob_model.sv
// Operator model for one three-position knob with two contacts.
// Assumes pos changes just after a clk_sys edge; bit 0 cw, bit 1 ccw.
`timescale 1ns/1ps
module dkm_knob_model
(
  input wire logic clk_sys,
  input wire logic [1:0] pos,
  output logic cw_raw,
  output logic ccw_raw
);
  logic [1:0] last_pos = 2'h0;
  int chatter = 0;
  initial
  begin
    cw_raw = 1'b0;
    ccw_raw = 1'b0;
  end
  // New contact chatters on, off, on: shorter than any debounce window
  always @(posedge clk_sys)
  begin
    #2;
    if (pos != last_pos)
    begin
      chatter = 3;
      last_pos = pos;
    end
    if (chatter > 0)
      chatter = chatter - 1;
    cw_raw = pos[0] & !chatter[0];
    ccw_raw = pos[1] & !chatter[0];
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the knob and menu control block.
// Assumes shortened timing parameters; knob pins come from two models.
`timescale 1ns/1ps
module tb_top
  import dkm_pkg::*;
();
  localparam int SLOW_T = 10;
  localparam int FAST_T = 3;
  typedef struct {
    logic [3:0] kind;
    logic [7:0] val;
    logic [4:0] disp;
  } dkm_note_type;
  logic clk_sys = 1'b0, reset = 1'b1, value_load = 1'b0, msg_rx = 1'b0;
  logic [1:0] ctl_pos = 2'h0, sel_pos = 2'h0;
  logic ctl_cw_raw, ctl_ccw_raw, sel_cw_raw, sel_ccw_raw;
  logic role_select_switch_a = 1'b0, role_select_switch_b = 1'b0;
  logic setup_mode = 1'b0, value_entry = 1'b0, led_swap = 1'b0;
  logic [7:0] value_in = 8'h00, value_min = 8'h03, value_max = 8'h07;
  logic rdu1_enable = 1'b0, rdu1_present = 1'b1;
  logic rdu2_enable = 1'b0, rdu2_present = 1'b1;
  dkm_mode_type rdu1_select = MODE_REMOTE, rdu2_select = MODE_REMOTE;
  logic alarm_active = 1'b0, valve_opening = 1'b0, valve_closing = 1'b0;
  logic at_open_limit = 1'b0, at_close_limit = 1'b0;
  logic cmd_open, cmd_stop, cmd_close, op_blocked, link_fail, msg_blank;
  logic yes_pulse, no_pulse, next_pulse, back_pulse;
  logic led_red, led_green, led_yellow, blk, anys, anyl, led_prev;
  dkm_mode_type op_mode, em;
  dkm_role_type role;
  logic [7:0] value_reg, ev;
  logic [4:0] disp_reg, ed;
  logic [31:0] r;
  logic [3:0] run_kind;
  int n_mismatch = 0, tests_run = 0, seed = 32'hC964, cyc = 0;
  int n_steps, t_prev, first_gap, last_gap, toggles;
  bit pend = 1'b0, free_run = 1'b0;
  dkm_note_type notes[$];
  dkm_note_type cur;
  wire [3:0] seen = {yes_pulse, no_pulse, next_pulse, back_pulse};

  dkm_knob_model u_ctl (.clk_sys, .pos(ctl_pos), .cw_raw(ctl_cw_raw),
    .ccw_raw(ctl_ccw_raw));
  dkm_knob_model u_sel (.clk_sys, .pos(sel_pos), .cw_raw(sel_cw_raw),
    .ccw_raw(sel_ccw_raw));
  dkm_knob_menu #(.DEB_CYC(32'h4), .SLOW_CYC(32'(SLOW_T)),
    .FAST_CYC(32'(FAST_T)), .FAST_AFTER_CYC(32'h28), .LINK_CYC(32'h32),
    .BLINK_HALF_CYC(32'h4)) u_dut (
    .clk_sys, .reset, .ctl_cw_raw, .ctl_ccw_raw, .sel_cw_raw, .sel_ccw_raw,
    .role_select_switch_a, .role_select_switch_b, .setup_mode, .value_entry,
    .value_load, .value_in, .value_min, .value_max, .rdu1_enable,
    .rdu1_present, .rdu1_select, .rdu2_enable, .rdu2_present, .rdu2_select,
    .msg_rx, .alarm_active, .valve_opening, .valve_closing, .at_open_limit,
    .at_close_limit, .led_swap, .cmd_open, .cmd_stop, .cmd_close, .op_mode,
    .op_blocked, .yes_pulse, .no_pulse, .next_pulse, .back_pulse, .value_reg,
    .disp_reg, .role, .link_fail, .msg_blank, .led_red, .led_green,
    .led_yellow);

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_val(input string what, input logic [7:0] e,
    input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic done(input string name);
    $display("Test %s done", name);
  endtask
  task automatic set_knob(input bit on_sel, input logic [1:0] p);
    if (on_sel)
      sel_pos = p;
    else
      ctl_pos = p;
  endtask
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v >= value_max) ? value_min : v + 8'h01;
  endfunction
  // Short press, then wait for the monitor to consume the note
  task automatic tap(input bit on_sel, input logic [1:0] p,
    input logic [3:0] kind);
    notes.push_back('{kind, ev, ed});
    set_knob(on_sel, p);
    cycles(8);
    set_knob(on_sel, 2'h0);
    for (int i = 0; i < 40 && (notes.size() > 0 || pend); i++)
      cycles(1);
    if (notes.size() > 0 || pend)
    begin
      n_mismatch++;
      $display("BAD pulse expected seen timeout");
      close_out();
    end
  endtask
  task automatic hold(input bit on_sel, input logic [1:0] p,
    input logic [3:0] kind);
    run_kind = kind;
    n_steps = 0;
    free_run = 1'b1;
    set_knob(on_sel, p);
    cycles(110);
    set_knob(on_sel, 2'h0);
    cycles(30);
    free_run = 1'b0;
    chk_val("slow gap", 8'(SLOW_T), 8'(first_gap));
    chk_val("fast gap", 8'(FAST_T), 8'(last_gap));
  endtask

  always @(posedge clk_sys)
  begin
    #2;
    if (pend)
    begin
      pend = 1'b0;
      chk_val("value_reg", cur.val, value_reg);
      chk_val("disp_reg", 8'(cur.disp), 8'(disp_reg));
    end
    if ((|seen) === 1'b1)
    begin
      if (free_run)
      begin
        chk_val("scroll kind", 8'(run_kind), 8'(seen));
        n_steps++;
        if (n_steps == 2)
          first_gap = cyc - t_prev;
        last_gap = cyc - t_prev;
        t_prev = cyc;
      end
      else if (notes.size() == 0)
        chk_val("stray pulse", 8'h00, 8'(seen));
      else
      begin
        cur = notes.pop_front();
        chk_val("pulse", 8'(cur.kind), 8'(seen));
        pend = 1'b1;
      end
    end
  end

  initial
  begin
    cycles(12);
    reset = 1'b0;
    cycles(2);
    chk_val("op_mode", 8'(MODE_STOP), 8'(op_mode));
    chk_bit("cmd_stop", 1'b1, cmd_stop);
    for (int t = 0; t < 12; t++)
    begin
      r = $random(seed);
      sel_pos = (r[1:0] == 2'h3) ? 2'h0 : r[1:0];
      rdu1_select = dkm_mode_type'((r[3:2] == 2'h3) ? 2'h0 : r[3:2]);
      rdu2_select = dkm_mode_type'((r[5:4] == 2'h3) ? 2'h0 : r[5:4]);
      {rdu2_enable, rdu1_enable} = r[7:6];
      rdu1_present = r[9:8] != 2'h0;
      rdu2_present = r[11:10] != 2'h0;
      blk = (rdu1_enable & !rdu1_present) | (rdu2_enable & !rdu2_present);
      anys = (sel_pos == 2'h0) | (rdu1_enable & rdu1_select == MODE_STOP)
        | (rdu2_enable & rdu2_select == MODE_STOP);
      anyl = (sel_pos == 2'h2) | (rdu1_enable & rdu1_select == MODE_LOCAL)
        | (rdu2_enable & rdu2_select == MODE_LOCAL);
      em = (blk | anys) ? MODE_STOP : anyl ? MODE_LOCAL : MODE_REMOTE;
      cycles(16);
      chk_val("op_mode", 8'(em), 8'(op_mode));
      chk_bit("op_blocked", blk, op_blocked);
    end
    {rdu2_enable, rdu1_enable} = 2'h0;
    sel_pos = 2'h2;
    ctl_pos = 2'h2;
    cycles(16);
    chk_bit("cmd_open", 1'b1, cmd_open);
    chk_bit("cmd_stop", 1'b0, cmd_stop);
    ctl_pos = 2'h1;
    cycles(16);
    chk_bit("cmd_close", 1'b1, cmd_close);
    rdu1_enable = 1'b1;
    rdu1_present = 1'b0;
    cycles(3);
    chk_bit("cmd_close", 1'b0, cmd_close);
    chk_bit("cmd_stop", 1'b1, cmd_stop);
    rdu1_enable = 1'b0;
    done("mode and commands");
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 32; i++)
      begin
        led_swap = s[0];
        {alarm_active, valve_opening, valve_closing, at_open_limit,
          at_close_limit} = 5'(i);
        cycles(3);
        chk_bit("msg_blank", i == 0, msg_blank);
        if (i < 16)
          chk_bit("led_yellow", i == 0, led_yellow);
        if (i == 1 || i == 2)
        begin
          chk_bit("led_red", (i == 2) ^ s[0], led_red);
          chk_bit("led_green", (i == 1) ^ s[0], led_green);
        end
      end
    done("message and indicators");
    for (int k = 0; k < 4; k++)
    begin
      {role_select_switch_b, role_select_switch_a} = 2'(k);
      cycles(16);
      chk_val("role", 8'(k), 8'(role));
    end
    role_select_switch_b = 1'b0;
    cycles(16);
    msg_rx = 1'b1;
    cycles(1);
    msg_rx = 1'b0;
    cycles(40);
    chk_bit("link_fail early", 1'b0, link_fail);
    cycles(20);
    chk_bit("link_fail", 1'b1, link_fail);
    led_prev = led_red;
    toggles = 0;
    repeat (16)
    begin
      cycles(1);
      toggles += int'(led_red !== led_prev);
      led_prev = led_red;
      chk_bit("led_green blink", led_red, led_green);
      chk_bit("led_yellow blink", led_red, led_yellow);
    end
    chk_bit("blinking", 1'b1, toggles >= 2 && toggles <= 4);
    msg_rx = 1'b1;
    cycles(1);
    msg_rx = 1'b0;
    cycles(3);
    chk_bit("link_fail cleared", 1'b0, link_fail);
    role_select_switch_a = 1'b0;
    ctl_pos = 2'h0;
    sel_pos = 2'h0;
    done("role and link");
    cycles(16);
    setup_mode = 1'b1;
    value_entry = 1'b1;
    value_in = 8'h03 + 8'($unsigned($random(seed)) % 5);
    value_load = 1'b1;
    cycles(1);
    value_load = 1'b0;
    cycles(2);
    ev = value_in;
    ed = 5'h00;
    chk_val("value loaded", ev, value_reg);
    repeat (6)
    begin
      ev = inc(ev);
      tap(1'b0, 2'h2, 4'h4);
    end
    ed = ed + 5'h01;
    tap(1'b0, 2'h1, 4'h8);
    value_entry = 1'b0;
    ed = ed + 5'h01;
    tap(1'b0, 2'h2, 4'h4);
    ed = ed + 5'h01;
    tap(1'b1, 2'h1, 4'h2);
    ed = ed - 5'h01;
    tap(1'b1, 2'h2, 4'h1);
    done("setup taps");
    value_entry = 1'b1;
    hold(1'b0, 2'h2, 4'h4);
    repeat (n_steps) ev = inc(ev);
    chk_val("held value", ev, value_reg);
    hold(1'b1, 2'h1, 4'h2);
    ed = 5'((int'(ed) + n_steps) % 20);
    chk_val("scrolled disp", 8'(ed), 8'(disp_reg));
    chk_val("value kept", ev, value_reg);
    done("held knobs");
    close_out();
  end
endmodule
